// ---- shared/ccsr_pkg.sv ----
package ccsr_pkg;

    // ------------------------------------------------------------
    // Host map
    // ------------------------------------------------------------
    localparam logic [4:0] ADDR_CTL  = 5'h00;
    localparam logic [4:0] ADDR_CMD  = 5'h01;
    localparam logic [4:0] ADDR_STAT = 5'h02;
    localparam logic [4:0] ADDR_NONE = 5'h1e;

    localparam logic [7:0] CMD_READ_VAL = 8'hff;
    localparam logic [7:0] NONE_READ_VAL = 8'h00;

    // ------------------------------------------------------------
    // Control byte fields
    // ------------------------------------------------------------
    localparam int CTL_TM   = 7;
    localparam int CTL_SYNC = 6;
    localparam int CTL_OIE  = 4;
    localparam int CTL_EIE  = 3;
    localparam int CTL_TIE  = 2;
    localparam int CTL_RIE  = 1;
    localparam int CTL_HALT = 0;
    localparam logic [7:0] CTL_WMASK = 8'hdf;
    localparam logic [7:0] CTL_RST   = 8'h01;

    // ------------------------------------------------------------
    // Command byte fields
    // ------------------------------------------------------------
    localparam int CMD_DOZE  = 4;
    localparam int CMD_OVCLR = 3;
    localparam int CMD_RXREL = 2;
    localparam int CMD_ABORT = 1;
    localparam int CMD_SEND  = 0;

    // ------------------------------------------------------------
    // Status byte fields
    // ------------------------------------------------------------
    localparam int ST_LINE_OFF = 7;
    localparam int ST_WARN     = 6;
    localparam int ST_SENDING  = 5;
    localparam int ST_RECV     = 4;
    localparam int ST_TX_DONE  = 3;
    localparam int ST_TX_FREE  = 2;
    localparam int ST_OVR      = 1;
    localparam int ST_RX_FULL  = 0;

    // ------------------------------------------------------------
    // Timing, in bit times and bus-free occurrences, and the receive slot count
    // ------------------------------------------------------------
    localparam int SLEEP_CLK_BITS = 15;
    localparam int RECOV_FREE_CNT = 128;
    localparam logic [1:0] RX_SLOTS = 2'd2;

    typedef enum logic [1:0] {
        CCSR_RUN  = 2'b00,
        CCSR_DOZE = 2'b01,
        CCSR_WAKE = 2'b11
    } ccsr_slp_st_t;

endpackage : ccsr_pkg

// ---- shared/ccsr_sleep_if.sv ----
`timescale 1ns/10ps
interface ccsr_sleep_if;
    logic doze;
    logic bus_act;
    logic irq_n;
    logic bit_tick;
    logic bus_free;
    logic asleep;
    logic clk_out_run;
    logic wake;
    logic rx_hold;

    modport ctrl (
        output doze, bus_act, irq_n, bit_tick, bus_free,
        input  asleep, clk_out_run, wake, rx_hold
    );
    modport slp (
        input  doze, bus_act, irq_n, bit_tick, bus_free,
        output asleep, clk_out_run, wake, rx_hold
    );
endinterface : ccsr_sleep_if

// ---- src/ccsr_regs.sv ----
`timescale 1ns/10ps
module ccsr_regs
    import ccsr_pkg::*;
#(
    parameter int RECOV_COUNT = RECOV_FREE_CNT
)
(
    // Clock and reset
    input  wire logic       clk_sys,
    input  wire logic       rst,
    // Host parallel port
    input  wire logic       host_cs,
    input  wire logic       host_wr,
    input  wire logic       host_rd,
    input  wire logic [4:0] host_addr,
    input  wire logic [7:0] host_wdata,
    output logic      [7:0] host_rdata,
    // Bit-stream engine
    input  wire logic       core_tx_start,
    input  wire logic       core_tx_end,
    input  wire logic       core_tx_ok,
    input  wire logic       core_tx_busy,
    input  wire logic       core_rx_busy,
    input  wire logic       core_rx_store,
    input  wire logic       core_bus_off,
    input  wire logic       core_err_warn,
    input  wire logic       core_bus_free,
    input  wire logic       core_bit_tick,
    // Pins
    input  wire logic       bus_activity_pin,
    input  wire logic       irq_line_n_pin,
    // Control outputs
    output logic            factory_check_mode,
    output logic            sync_mode,
    output logic      [3:0] irq_on,
    output logic            core_halt_request,
    output logic            tx_go,
    output logic            rx_present_slot,
    output logic            rx_enable,
    output logic            irq_flags_clr,
    output logic            err_cnt_clear,
    // Events
    output logic            ev_tx_release,
    output logic            ev_rx_new,
    output logic            ev_overrun,
    output logic            ev_wake,
    // Sleep
    output logic            doze_active,
    output logic            aux_clock_run
);

    typedef struct packed {
        logic [7:0] ctl;
        logic       doze;
        logic       tx_pend;
        logic       tx_act;
        logic       tx_done;
        logic       tx_free;
        logic [1:0] rx_cnt;
        logic       rx_head;
        logic       rx_full;
        logic       ovr;
        logic       line_off;
        logic       warn;
        logic [7:0] free_cnt;
        logic [7:0] rdata;
        logic       ev_tx;
        logic       ev_rx;
        logic       ev_ovr;
        logic       err_clr;
        logic [1:0] s_bus;
        logic [1:0] s_irq;
    } ccsr_q_t;

    // ------------------------------------------------------------
    // Reset image of the state
    // ------------------------------------------------------------
    localparam ccsr_q_t Q_RST = '{
        ctl:      CTL_RST,
        doze:     1'b0,
        tx_pend:  1'b0,
        tx_act:   1'b0,
        tx_done:  1'b1,
        tx_free:  1'b1,
        rx_cnt:   2'd0,
        rx_head:  1'b0,
        rx_full:  1'b0,
        ovr:      1'b0,
        line_off: 1'b0,
        warn:     1'b0,
        free_cnt: 8'h00,
        rdata:    8'h00,
        ev_tx:    1'b0,
        ev_rx:    1'b0,
        ev_ovr:   1'b0,
        err_clr:  1'b0,
        s_bus:    2'b00,
        s_irq:    2'b11
    };

    ccsr_q_t q;
    ccsr_q_t next_q;

    // ------------------------------------------------------------
    // Link to the sleep controller
    // ------------------------------------------------------------
    ccsr_sleep_if sl ();

    logic       halt;
    logic       wr_ctl;
    logic       wr_cmd;
    logic       rd;
    logic       sending;
    logic       receiving;
    logic [7:0] status;

    // ------------------------------------------------------------
    // Decode and status
    // ------------------------------------------------------------
    assign halt   = q.ctl[CTL_HALT];
    assign wr_ctl = host_cs && host_wr && (host_addr == ADDR_CTL);
    assign wr_cmd = host_cs && host_wr && (host_addr == ADDR_CMD);
    assign rd     = host_cs && host_rd;

    assign sending   = core_tx_busy && !halt;
    assign receiving = core_rx_busy && !halt && !sl.rx_hold;

    always_comb begin
        status              = 8'h00;
        status[ST_LINE_OFF] = q.line_off;
        status[ST_WARN]     = q.warn;
        status[ST_SENDING]  = sending;
        status[ST_RECV]     = receiving;
        status[ST_TX_DONE]  = q.tx_done;
        status[ST_TX_FREE]  = q.tx_free;
        status[ST_OVR]      = q.ovr;
        status[ST_RX_FULL]  = q.rx_full;
    end

    // ------------------------------------------------------------
    // Next state
    // ------------------------------------------------------------
    always_comb begin
        next_q         = q;
        next_q.ev_tx   = 1'b0;
        next_q.ev_rx   = 1'b0;
        next_q.ev_ovr  = 1'b0;
        next_q.err_clr = 1'b0;
        next_q.s_bus   = {q.s_bus[0], bus_activity_pin};
        next_q.s_irq   = {q.s_irq[0], irq_line_n_pin};

        // ------------------------------------------------------------
        // Host read data
        // ------------------------------------------------------------
        if (rd) begin
            case (host_addr)
                ADDR_CTL:  next_q.rdata = q.ctl;
                ADDR_CMD:  next_q.rdata = CMD_READ_VAL;
                ADDR_STAT: next_q.rdata = status;
                ADDR_NONE: next_q.rdata = NONE_READ_VAL;
                default:   next_q.rdata = NONE_READ_VAL;
            endcase
        end

        // ------------------------------------------------------------
        // Control byte; reserved bit stays zero
        // ------------------------------------------------------------
        if (wr_ctl) begin
            next_q.ctl = host_wdata & CTL_WMASK;
        end

        // ------------------------------------------------------------
        // Transmit engine handshake
        // ------------------------------------------------------------
        if (core_tx_start && q.tx_pend) begin
            next_q.tx_act  = 1'b1;
            next_q.tx_pend = 1'b0;
        end
        if (core_tx_end && q.tx_act) begin
            next_q.tx_act  = 1'b0;
            next_q.tx_done = core_tx_ok;
            next_q.tx_free = 1'b1;
            next_q.ev_tx   = 1'b1;
        end

        // ------------------------------------------------------------
        // Commands are ignored while halted
        // ------------------------------------------------------------
        if (wr_cmd && !halt) begin
            next_q.doze = host_wdata[CMD_DOZE];
            if (host_wdata[CMD_SEND]) begin
                // A later low bit never cancels
                next_q.tx_pend = 1'b1;
                next_q.tx_done = 1'b0;
                next_q.tx_free = 1'b0;
            end
            if (host_wdata[CMD_ABORT] && next_q.tx_pend
                && !next_q.tx_act) begin
                next_q.tx_pend = 1'b0;
                next_q.tx_free = 1'b1;
                next_q.ev_tx   = 1'b1;
            end
            if (host_wdata[CMD_RXREL] && q.rx_cnt != 2'd0) begin
                next_q.rx_cnt  = q.rx_cnt - 2'd1;
                next_q.rx_head = !q.rx_head;
                next_q.rx_full = (q.rx_cnt == RX_SLOTS);
            end else if (host_wdata[CMD_RXREL]) begin
                next_q.rx_full = 1'b0;
            end
            if (host_wdata[CMD_OVCLR]) begin
                next_q.ovr = 1'b0;
            end
        end

        // ------------------------------------------------------------
        // New message stored; set wins over clear
        // ------------------------------------------------------------
        if (core_rx_store) begin
            if (next_q.rx_cnt == RX_SLOTS) begin
                next_q.ovr    = 1'b1;
                next_q.ev_ovr = 1'b1;
            end else begin
                next_q.rx_cnt  = next_q.rx_cnt + 2'd1;
                next_q.rx_full = 1'b1;
                next_q.ev_rx   = 1'b1;
            end
        end

        // ------------------------------------------------------------
        // Bus-off recovery after the host lifts the halt
        // ------------------------------------------------------------
        if (q.line_off && !halt && core_bus_free) begin
            if (q.free_cnt == 8'(RECOV_COUNT - 1)) begin
                next_q.line_off = 1'b0;
                next_q.warn     = 1'b0;
                next_q.free_cnt = 8'h00;
                next_q.err_clr  = 1'b1;
            end else begin
                next_q.free_cnt = q.free_cnt + 8'h01;
            end
        end
        if (core_bus_off) begin
            next_q.line_off      = 1'b1;
            next_q.ctl[CTL_HALT] = 1'b1;
            next_q.free_cnt      = 8'h00;
        end

        // ------------------------------------------------------------
        // Error warning; a new warning beats recovery
        // ------------------------------------------------------------
        if (core_err_warn) begin
            next_q.warn = 1'b1;
        end

        // ------------------------------------------------------------
        // Halt forcing; line-off and warn untouched
        // ------------------------------------------------------------
        if (next_q.ctl[CTL_HALT]) begin
            next_q.ctl[CTL_TM] = 1'b0;
            next_q.doze        = 1'b0;
            next_q.tx_pend     = 1'b0;
            next_q.tx_act      = 1'b0;
            next_q.tx_done     = 1'b1;
            next_q.tx_free     = 1'b1;
            next_q.ovr         = 1'b0;
            next_q.rx_full     = 1'b0;
            next_q.rx_cnt      = 2'd0;
            next_q.rx_head     = 1'b0;
            next_q.ev_rx       = 1'b0;
            next_q.ev_ovr      = 1'b0;
        end
    end

    // ------------------------------------------------------------
    // Register stage
    // ------------------------------------------------------------
    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            q <= Q_RST;
        end else begin
            q <= next_q;
        end
    end

    // ------------------------------------------------------------
    // Sleep controller
    // ------------------------------------------------------------
    assign sl.doze     = q.doze;
    assign sl.bus_act  = q.s_bus[1];
    assign sl.irq_n    = q.s_irq[1];
    assign sl.bit_tick = core_bit_tick;
    assign sl.bus_free = core_bus_free;

    ccsr_sleep_ctl u_sleep (
        .clk_sys (clk_sys),
        .rst     (rst),
        .sl      (sl.slp)
    );

    // ------------------------------------------------------------
    // Outputs
    // ------------------------------------------------------------
    assign host_rdata         = q.rdata;
    assign factory_check_mode = q.ctl[CTL_TM];
    assign sync_mode          = q.ctl[CTL_SYNC];
    assign irq_on             = {q.ctl[CTL_OIE], q.ctl[CTL_EIE],
                                 q.ctl[CTL_TIE], q.ctl[CTL_RIE]};
    assign core_halt_request  = halt;
    assign tx_go              = q.tx_pend;
    assign rx_present_slot    = q.rx_head;
    assign rx_enable          = !halt && !sl.rx_hold;
    assign irq_flags_clr      = halt;
    assign err_cnt_clear      = q.err_clr;
    assign ev_tx_release      = q.ev_tx;
    assign ev_rx_new          = q.ev_rx;
    assign ev_overrun         = q.ev_ovr;
    assign ev_wake            = sl.wake;
    assign doze_active        = sl.asleep;
    assign aux_clock_run      = sl.clk_out_run;

endmodule : ccsr_regs

// ---- src/ccsr_sleep_ctl.sv ----
`timescale 1ns/10ps
module ccsr_sleep_ctl
    import ccsr_pkg::*;
(
    // Clock and reset
    input wire logic clk_sys,
    input wire logic rst,
    // Link to register logic
    ccsr_sleep_if.slp sl
);

    typedef struct packed {
        ccsr_slp_st_t st;
        logic [4:0]   bits;
        logic         clk_run;
        logic         wake;
        logic         hold;
        logic         by_bus;
    } ccsr_slp_q_t;

    ccsr_slp_q_t q;
    ccsr_slp_q_t next_q;

    logic go_sleep;
    logic wake_cause;

    assign go_sleep   = sl.doze && !sl.bus_act && sl.irq_n;
    assign wake_cause = !sl.doze || sl.bus_act || !sl.irq_n;

    always_comb begin
        next_q      = q;
        next_q.wake = 1'b0;
        case (q.st)
            CCSR_RUN: begin
                next_q.clk_run = 1'b1;
                if (go_sleep) begin
                    next_q.st   = CCSR_DOZE;
                    next_q.bits = 5'd0;
                end
            end
            CCSR_DOZE: begin
                // Clock output lingers for the given bit times
                if (sl.bit_tick && q.clk_run) begin
                    if (q.bits == 5'(SLEEP_CLK_BITS - 1)) begin
                        next_q.clk_run = 1'b0;
                    end else begin
                        next_q.bits = q.bits + 5'd1;
                    end
                end
                if (wake_cause) begin
                    next_q.st     = CCSR_WAKE;
                    next_q.by_bus = sl.bus_act;
                end
            end
            CCSR_WAKE: begin
                next_q.st      = CCSR_RUN;
                next_q.clk_run = 1'b1;
                next_q.wake    = 1'b1;
                next_q.hold    = q.hold || q.by_bus;
            end
            default: begin
                next_q.st = CCSR_RUN;
            end
        endcase
        // Waking frame is skipped until the bus goes free
        if (q.hold && sl.bus_free) begin
            next_q.hold = 1'b0;
        end
    end

    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            q <= '{st: CCSR_RUN, bits: 5'd0, clk_run: 1'b1,
                   wake: 1'b0, hold: 1'b0, by_bus: 1'b0};
        end else begin
            q <= next_q;
        end
    end

    assign sl.asleep      = (q.st == CCSR_DOZE);
    assign sl.clk_out_run = q.clk_run;
    assign sl.wake        = q.wake;
    assign sl.rx_hold     = q.hold;

endmodule : ccsr_sleep_ctl

// ---- test/ccsr_host_model.sv ----
`timescale 1ns/10ps
module ccsr_host_model
    import ccsr_pkg::*;
(
    // Clock
    input  wire logic       clk_sys,
    // Host port
    output logic            host_cs,
    output logic            host_wr,
    output logic            host_rd,
    output logic      [4:0] host_addr,
    output logic      [7:0] host_wdata,
    input  wire logic [7:0] host_rdata
);
    initial begin
        host_cs = 1'b0;
        host_wr = 1'b0;
        host_rd = 1'b0;
        host_addr = 5'h1f;
        host_wdata = 8'h00;
    end

    task automatic wr_byte(input logic [4:0] a, input logic [7:0] d);
        @(negedge clk_sys);
        {host_cs, host_wr, host_addr, host_wdata} = {2'b11, a, d};
        @(negedge clk_sys);
        {host_cs, host_wr, host_wdata} = {2'b00, ~d};
    endtask : wr_byte

    task automatic rd_byte(input logic [4:0] a, output logic [7:0] d);
        @(negedge clk_sys);
        {host_cs, host_rd, host_addr} = {2'b11, a};
        @(negedge clk_sys);
        {host_cs, host_rd} = 2'b00;
        d = host_rdata;
    endtask : rd_byte
endmodule : ccsr_host_model

// ---- test/ccsr_regs_props.sv ----
`timescale 1ns/10ps
module ccsr_regs_props
    import ccsr_pkg::*;
#(
    parameter int RECOV_COUNT = RECOV_FREE_CNT
)
(
    // Clock and reset
    input wire logic       clk_sys,
    input wire logic       rst,
    // Host port
    input wire logic       host_cs,
    input wire logic       host_wr,
    input wire logic       host_rd,
    input wire logic [4:0] host_addr,
    input wire logic [7:0] host_wdata,
    input wire logic [7:0] host_rdata,
    // Engine side
    input wire logic       core_tx_start,
    input wire logic       core_bus_off,
    input wire logic       core_bus_free,
    input wire logic       core_rx_store,
    // Outputs watched
    input wire logic       ev_rx_new,
    input wire logic       factory_check_mode,
    input wire logic       core_halt_request,
    input wire logic       tx_go,
    input wire logic       rx_enable,
    input wire logic       irq_flags_clr,
    input wire logic       err_cnt_clear,
    input wire logic       ev_tx_release,
    input wire logic       ev_overrun,
    input wire logic       ev_wake,
    input wire logic       doze_active,
    input wire logic       aux_clock_run
);
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (rst);

    wire logic ctl_wr = host_cs && host_wr && host_addr == ADDR_CTL;
    wire logic cmd_wr = host_cs && host_wr && host_addr == ADDR_CMD
                        && !core_halt_request;
    wire logic ab_wr  = cmd_wr && host_wdata[CMD_ABORT];

    a_cmd_reads_ones: assert property (
        host_cs && host_rd && host_addr == ADDR_CMD
        |=> host_rdata == CMD_READ_VAL) else $error("cmd read not ones");
    a_none_reads_zero: assert property (
        host_cs && host_rd && host_addr == ADDR_NONE
        |=> host_rdata == NONE_READ_VAL) else $error("addr 30 not empty");
    a_halt_test_off: assert property (
        core_halt_request |-> !factory_check_mode) else $error("test on");
    a_halt_no_send: assert property (
        core_halt_request && $past(core_halt_request) |-> !tx_go)
        else $error("send while halted");
    a_halt_clr_irq: assert property (
        irq_flags_clr == core_halt_request) else $error("irq clear wrong");
    a_send_sets_go: assert property (
        cmd_wr && host_wdata[CMD_SEND] && !host_wdata[CMD_ABORT]
        && !core_bus_off && !ctl_wr |=> tx_go) else $error("send not taken");
    a_go_holds: assert property (
        tx_go && !core_tx_start && !ab_wr && !core_halt_request
        && !core_bus_off && !ctl_wr |=> tx_go) else $error("send lost");
    a_abort_cancel: assert property (
        ab_wr && tx_go && !core_tx_start |=> !tx_go && ev_tx_release)
        else $error("abort not honoured");
    a_store_event: assert property (
        core_rx_store && !core_halt_request && !ctl_wr && !core_bus_off
        |=> ev_rx_new != ev_overrun) else $error("store event wrong");
    a_busoff_halt: assert property (
        core_bus_off |=> core_halt_request) else $error("no halt");
    a_recover_free: assert property (
        err_cnt_clear |-> $past(core_bus_free)) else $error("early clear");
    a_rx_gate: assert property (
        rx_enable |-> !core_halt_request) else $error("rx while halted");
    a_bus_wake: assert property (
        $rose(rx_enable) && !$past(core_halt_request)
        |-> $past(core_bus_free)) else $error("rx before bus free");
    a_wake_event: assert property (
        $fell(doze_active) |-> ##[0:2] (ev_wake && aux_clock_run))
        else $error("no wake event");

    cover property (ev_wake);
    cover property (err_cnt_clear);
    cover property (ev_overrun);
    cover property (tx_go ##1 !tx_go);
endmodule : ccsr_regs_props

bind ccsr_regs ccsr_regs_props #(.RECOV_COUNT(RECOV_COUNT)) chk_u (
    .clk_sys, .rst, .host_cs, .host_wr, .host_rd, .host_addr,
    .host_wdata, .host_rdata, .core_tx_start, .core_bus_off,
    .core_bus_free, .core_rx_store, .ev_rx_new,
    .factory_check_mode, .core_halt_request, .tx_go,
    .rx_enable, .irq_flags_clr, .err_cnt_clear, .ev_tx_release,
    .ev_overrun, .ev_wake, .doze_active, .aux_clock_run
);

// ---- test/ccsr_regs_tb.sv ----
`timescale 1ns/10ps
`define CHK(n, e, g) begin samples_checked++; if ((g) !== (e)) begin \
    error_cnt++; $display("unexpected %s exp %h got %h", n, e, g); end end
module ccsr_regs_tb
    import ccsr_pkg::*;
;
    localparam int RC = 4;
    logic       clk_sys = 1'b0;
    logic       rst = 1'b1;
    logic       host_cs, host_wr, host_rd;
    logic [4:0] host_addr;
    logic [7:0] host_wdata, host_rdata;
    // Pulses: start, end, store, bus off, bus free, bit tick
    logic [5:0] stb = 6'h00;
    logic       tx_ok = 1'b0, tx_busy = 1'b0, rx_busy = 1'b0;
    logic       warn = 1'b0, bus_act = 1'b0, irq_n = 1'b1;
    logic       fcm, sync, halt, go, slot, rx_en, doze, aux;
    logic [3:0] irq_on;
    int         error_cnt = 0;
    int         samples_checked = 0;
    int         cycles = 0;

    always #2.5 clk_sys = ~clk_sys;

    ccsr_host_model host_u (.clk_sys, .host_cs, .host_wr, .host_rd,
        .host_addr, .host_wdata, .host_rdata);

    ccsr_regs #(.RECOV_COUNT(RC)) dut_u (
        .clk_sys, .rst, .host_cs, .host_wr, .host_rd, .host_addr,
        .host_wdata, .host_rdata, .core_tx_start(stb[0]),
        .core_tx_end(stb[1]), .core_tx_ok(tx_ok), .core_tx_busy(tx_busy),
        .core_rx_busy(rx_busy), .core_rx_store(stb[2]),
        .core_bus_off(stb[3]), .core_err_warn(warn),
        .core_bus_free(stb[4]), .core_bit_tick(stb[5]),
        .bus_activity_pin(bus_act), .irq_line_n_pin(irq_n),
        .factory_check_mode(fcm), .sync_mode(sync), .irq_on(irq_on),
        .core_halt_request(halt), .tx_go(go), .rx_present_slot(slot),
        .rx_enable(rx_en), .irq_flags_clr(), .err_cnt_clear(),
        .ev_tx_release(), .ev_rx_new(), .ev_overrun(), .ev_wake(),
        .doze_active(doze), .aux_clock_run(aux));

    task automatic end_of_test();
        $display("errors %0d checks %0d", error_cnt, samples_checked);
        if (error_cnt == 0 && samples_checked > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask : end_of_test

    task automatic pulse(input int k, input int n);
        repeat (n) begin
            @(negedge clk_sys) stb[k] = 1'b1;
            @(negedge clk_sys) stb[k] = 1'b0;
        end
    endtask : pulse

    task automatic chk_rd(input logic [4:0] a, input logic [7:0] e);
        logic [7:0] v;
        host_u.rd_byte(a, v);
        `CHK("read data", e, v)
    endtask : chk_rd

    task automatic wait_n(input int n);
        repeat (n) @(negedge clk_sys);
    endtask : wait_n

    always @(posedge clk_sys) begin
        cycles++;
        if (cycles == 6000) begin
            error_cnt++;
            end_of_test();
        end
    end

    initial begin
        logic s;
        wait_n(5);
        rst = 1'b0;
        chk_rd(ADDR_CTL, CTL_RST);
        chk_rd(ADDR_STAT, 8'h0c);
        chk_rd(ADDR_CMD, CMD_READ_VAL);
        chk_rd(ADDR_NONE, NONE_READ_VAL);
        host_u.wr_byte(ADDR_CTL, 8'hff);
        `CHK("test mode", 1'b0, fcm)
        host_u.wr_byte(ADDR_CTL, 8'hde);
        chk_rd(ADDR_CTL, 8'hde);
        `CHK("ctl outs", 6'h3f, {fcm, sync, irq_on})
        host_u.wr_byte(ADDR_CTL, 8'h00);
        host_u.wr_byte(ADDR_STAT, 8'hff);
        chk_rd(ADDR_STAT, 8'h0c);
        // Send, late abort, completion
        host_u.wr_byte(ADDR_CMD, 8'h01);
        chk_rd(ADDR_STAT, 8'h00);
        host_u.wr_byte(ADDR_CMD, 8'h00);
        `CHK("send pending", 1'b1, go)
        pulse(0, 1);
        host_u.wr_byte(ADDR_CMD, 8'h02);
        chk_rd(ADDR_STAT, 8'h00);
        tx_ok = 1'b1;
        pulse(1, 1);
        chk_rd(ADDR_STAT, 8'h0c);
        // Receive into both slots, then overrun
        pulse(2, 3);
        chk_rd(ADDR_STAT, 8'h0f);
        s = slot;
        host_u.wr_byte(ADDR_CMD, 8'h0c);
        chk_rd(ADDR_STAT, 8'h0d);
        `CHK("slot", ~s, slot)
        host_u.wr_byte(ADDR_CMD, 8'h04);
        chk_rd(ADDR_STAT, 8'h0c);
        // Abort before start
        host_u.wr_byte(ADDR_CMD, 8'h01);
        host_u.wr_byte(ADDR_CMD, 8'h02);
        chk_rd(ADDR_STAT, 8'h04);
        `CHK("send pending", 1'b0, go)
        // Halt masks engine activity
        {tx_busy, rx_busy} = 2'b11;
        chk_rd(ADDR_STAT, 8'h34);
        host_u.wr_byte(ADDR_CTL, 8'h01);
        chk_rd(ADDR_STAT, 8'h0c);
        host_u.wr_byte(ADDR_CMD, 8'h01);
        `CHK("send pending", 1'b0, go)
        {tx_busy, rx_busy} = 2'b00;
        // Bus-off and recovery
        host_u.wr_byte(ADDR_CTL, 8'h00);
        @(negedge clk_sys) warn = 1'b1;
        @(negedge clk_sys) warn = 1'b0;
        pulse(3, 1);
        `CHK("halt", 1'b1, halt)
        chk_rd(ADDR_STAT, 8'hcc);
        host_u.wr_byte(ADDR_CTL, 8'h00);
        pulse(4, RC - 1);
        chk_rd(ADDR_STAT, 8'hcc);
        pulse(4, 1);
        chk_rd(ADDR_STAT, 8'h0c);
        // Sleep and clock run-out
        host_u.wr_byte(ADDR_CMD, 8'h10);
        wait_n(3);
        `CHK("asleep", 1'b1, doze)
        pulse(5, SLEEP_CLK_BITS - 1);
        `CHK("clock run", 1'b1, aux)
        pulse(5, 1);
        wait_n(2);
        `CHK("clock run", 1'b0, aux)
        bus_act = 1'b1;
        wait_n(6);
        `CHK("awake", 3'b010, {doze, aux, rx_en})
        host_u.wr_byte(ADDR_CMD, 8'h00);
        bus_act = 1'b0;
        wait_n(3);
        `CHK("rx gate", 1'b0, rx_en)
        pulse(4, 1);
        `CHK("rx gate", 1'b1, rx_en)
        for (int c = 0; c < 2; c++) begin
            host_u.wr_byte(ADDR_CMD, 8'h10);
            wait_n(3);
            `CHK("asleep", 1'b1, doze)
            if (c == 0) host_u.wr_byte(ADDR_CMD, 8'h00);
            else irq_n = 1'b0;
            wait_n(6);
            `CHK("asleep", 1'b0, doze)
            host_u.wr_byte(ADDR_CMD, 8'h10);
            wait_n(6);
            `CHK("asleep", c == 0, doze)
            host_u.wr_byte(ADDR_CMD, 8'h00);
            irq_n = 1'b1;
        end
        wait_n(4);
        end_of_test();
    end
endmodule : ccsr_regs_tb
